/* shared/ims_pkg.sv */
package ims_pkg;
    // Bus widths and decode
    localparam int AHB_W = 32;
    localparam int DEC_W = 8;
    localparam int HTRANS_ACT = 1;
    localparam logic HRESP_OKAY = 1'h0;

    // Register byte offsets
    localparam logic [DEC_W-1:0] OFS_CTRL2 = 8'h00;
    localparam logic [DEC_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [DEC_W-1:0] OFS_FLAGS = 8'h08;
    localparam logic [DEC_W-1:0] OFS_BUFFER = 8'h0C;
    localparam logic [DEC_W-1:0] OFS_BAUD = 8'h10;

    // Second control register fields
    localparam int C2_SEN = 0;
    localparam int C2_REPEATED_START_REQUEST = 1;
    localparam int C2_RECEIVE_ENABLE_BIT = 3;
    localparam int C2_ACK_SEQUENCE_ENABLE = 4;
    localparam int C2_ACK_VALUE_BIT = 5;
    localparam int C2_ACK_STATUS_BIT = 6;

    // Status register fields
    localparam int ST_BF = 0;
    localparam int ST_BUSY = 1;

    // Sticky flag register fields, write one to clear
    localparam int FL_WRITE_COLLISION_FLAG = 0;
    localparam int FL_OVF = 1;
    localparam int FL_SIF = 2;
    localparam int FL_BCL = 3;
    localparam int FL_START = 4;

    // Baud counter and byte framing
    localparam int BAUD_W = 7;
    localparam int BYTE_W = 8;
    localparam logic [BAUD_W-1:0] BAUD_RESET = 7'h00;
    localparam logic [BAUD_W-1:0] BRG_ONE = 7'h01;
    localparam logic [0:0] QTICK_LAST = 1'h1;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_CHK = 4'b0001,
        S_HOLD = 4'b0010,
        R_LOW = 4'b0011,
        R_REL = 4'b0100,
        R_WAITH = 4'b0101,
        R_HIGH = 4'b0110,
        R_SDA = 4'b0111,
        B_LOW = 4'b1000,
        B_WAITH = 4'b1001,
        B_HIGH = 4'b1010
    } ims_state_t;

    typedef enum logic [1:0] {
        MODE_TX = 2'b00,
        MODE_RX = 2'b01,
        MODE_ACK = 2'b10
    } ims_mode_t;
endpackage

/* core/ims_master.sv */
// Functional notes
// R1: Counter pauses until released SCL reads high
// R2: SCL high lasts at least one period
// R3: Start: both high, one period, SDA low
// R4: Second period, clear request, hold SDA low
// R5: Start aborts on low lines, flags collision
// R6: Buffer write during start discarded, collision flag
// R7: Request bits locked during start sequences
// R8: Repeated start: SCL low, release SDA, SCL
// R9: Both high one period, SDA low, finish
// R10: Start bit immediate, interrupt after timeout
// R11: Repeated start ignored while busy
// R12: Repeated start collision on SDA or SCL
// R13: Buffer write sets full, starts counter
// R14: Bit after fall, low then high periods
// R15: Eighth fall clears full, releases SDA
// R16: Ninth clock samples acknowledge into status
// R17: After ninth clock: interrupt, SCL low, wait
// R18: Write during shifting discarded, sticky collision
// R19: Receive enable only accepted when idle
// R20: Receive eight bits, load buffer, stop
// R21: Buffer read clears full; ack sequence available
// R22: Byte arrives with full set: overflow
// R23: Reload from seven-bit field, count, stop
// R24: Counter steps twice per instruction cycle
`timescale 1ns/1ps
`default_nettype none
module ims_master (
    input wire logic hclk, // Bus and core clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [ims_pkg::AHB_W-1:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Word transfers only
    input wire logic [ims_pkg::AHB_W-1:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Always ready
    output logic [ims_pkg::AHB_W-1:0] hrdata, // Read data
    output logic hresp, // Always OKAY
    input wire logic scl_i, // Clock line level
    output logic scl_o, // Clock drive value, low
    output logic scl_oe, // Clock line pulled low
    input wire logic sda_i, // Data line level
    output logic sda_o, // Data drive value, low
    output logic sda_oe // Data line pulled low
);
    import ims_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // Line sampling and counter step enable
    logic [2:0] scl_sync_reg, sda_sync_reg;
    logic [0:0] tick_cnt_reg;
    logic scl_q_reg, sda_q_reg, tick_reg;
    // Three-stage sync, change taken when stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {scl_sync_reg, sda_sync_reg, scl_q_reg, sda_q_reg} <= '1;
            {tick_cnt_reg, tick_reg} <= '0;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_q_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_q_reg <= sda_sync_reg[2];
            end
            tick_cnt_reg <= tick_cnt_reg + 1'h1;
            tick_reg <= (tick_cnt_reg == QTICK_LAST); // R24
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    logic ap_valid_reg, ap_valid_next, ap_write_reg, ap_write_next;
    logic [DEC_W-1:0] ap_addr_reg, ap_addr_next;
    logic [AHB_W-1:0] hrdata_reg, hrdata_next;
    logic ap_take, wr_ctrl2, wr_flags, wr_buf, wr_baud, rd_buf;
    // Core state declared early for the read mux
    ims_state_t state_reg, state_next;
    ims_mode_t mode_reg, mode_next;
    logic [BAUD_W-1:0] brg_reg, brg_next, address_baud_reg, address_baud_next;
    logic brg_run_reg, brg_run_next, brg_load, brg_done;
    logic [3:0] bitcnt_reg, bitcnt_next;
    logic [BYTE_W-1:0] shift_register_reg, shift_register_next;
    logic [BYTE_W-1:0] transfer_buffer_reg, transfer_buffer_next;
    logic start_request_reg, start_request_next, repeated_start_request_reg;
    logic repeated_start_request_next, receive_enable_bit_reg, receive_enable_bit_next;
    logic ack_sequence_enable_reg, ack_sequence_enable_next, ack_value_bit_reg;
    logic ack_value_bit_next, ack_status_bit_reg, ack_status_bit_next;
    logic buffer_full_flag_reg, buffer_full_flag_next, write_collision_flag_reg;
    logic write_collision_flag_next, receive_overflow_flag_reg, receive_overflow_flag_next;
    logic serial_interrupt_flag_reg, serial_interrupt_flag_next, bus_collision_flag_reg;
    logic bus_collision_flag_next, start_seen_reg, start_seen_next;
    logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
    logic pin_low_reg, req_pending;
    // Address phase capture, data phase strobes, registered read data
    always_comb begin
        ap_take = hsel & htrans[HTRANS_ACT] & hready;
        ap_valid_next = ap_take;
        ap_write_next = ap_take & hwrite;
        ap_addr_next = ap_take ? haddr[DEC_W-1:0] : ap_addr_reg;
        wr_ctrl2 = ap_valid_reg & ap_write_reg & (ap_addr_reg == OFS_CTRL2);
        wr_flags = ap_valid_reg & ap_write_reg & (ap_addr_reg == OFS_FLAGS);
        wr_buf = ap_valid_reg & ap_write_reg & (ap_addr_reg == OFS_BUFFER);
        wr_baud = ap_valid_reg & ap_write_reg & (ap_addr_reg == OFS_BAUD);
        rd_buf = ap_take & ~hwrite & (haddr[DEC_W-1:0] == OFS_BUFFER);
        hrdata_next = '0;
        if (ap_take && !hwrite) begin
            unique case (haddr[DEC_W-1:0])
                OFS_CTRL2: hrdata_next[C2_ACK_STATUS_BIT:C2_SEN] = {ack_status_bit_reg,
                    ack_value_bit_reg, ack_sequence_enable_reg, receive_enable_bit_reg, 1'h0,
                    repeated_start_request_reg, start_request_reg};
                OFS_STATUS: hrdata_next[ST_BUSY:ST_BF] = {state_reg != S_IDLE,
                    buffer_full_flag_reg};
                OFS_FLAGS: hrdata_next[FL_START:FL_WRITE_COLLISION_FLAG] = {start_seen_reg,
                    bus_collision_flag_reg, serial_interrupt_flag_reg,
                    receive_overflow_flag_reg, write_collision_flag_reg};
                OFS_BUFFER: hrdata_next[BYTE_W-1:0] = transfer_buffer_reg;
                OFS_BAUD: hrdata_next[BAUD_W-1:0] = address_baud_reg;
                default: hrdata_next = '0;
            endcase
        end
    end
    // Address phase and read data registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {ap_valid_reg, ap_write_reg, ap_addr_reg, hrdata_reg} <= '0;
        end else begin
            {ap_valid_reg, ap_write_reg, ap_addr_reg, hrdata_reg} <= {ap_valid_next,
                ap_write_next, ap_addr_next, hrdata_next};
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Sequencer, baud counter and software-visible bits
    assign brg_done = tick_reg & brg_run_reg & (brg_reg == '0);
    assign req_pending = start_request_reg | repeated_start_request_reg
        | receive_enable_bit_reg | ack_sequence_enable_reg;
    // Next values of sequencer, counter and flags
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        brg_load = 1'h0;
        bitcnt_next = bitcnt_reg;
        shift_register_next = shift_register_reg;
        transfer_buffer_next = transfer_buffer_reg;
        address_baud_next = wr_baud ? hwdata[BAUD_W-1:0] : address_baud_reg;
        start_request_next = start_request_reg;
        repeated_start_request_next = repeated_start_request_reg;
        receive_enable_bit_next = receive_enable_bit_reg;
        ack_sequence_enable_next = ack_sequence_enable_reg;
        ack_value_bit_next = wr_ctrl2 ? hwdata[C2_ACK_VALUE_BIT] : ack_value_bit_reg;
        ack_status_bit_next = ack_status_bit_reg;
        scl_oe_next = scl_oe_reg;
        sda_oe_next = sda_oe_reg;
        // Sequence requests accepted only while idle
        if (wr_ctrl2 && state_reg == S_IDLE) begin // R7 R11 R19
            start_request_next = hwdata[C2_SEN];
            repeated_start_request_next = hwdata[C2_REPEATED_START_REQUEST];
            receive_enable_bit_next = hwdata[C2_RECEIVE_ENABLE_BIT];
            ack_sequence_enable_next = hwdata[C2_ACK_SEQUENCE_ENABLE];
        end
        // Software clears first so hardware sets win
        buffer_full_flag_next = buffer_full_flag_reg & ~rd_buf; // R21
        write_collision_flag_next = write_collision_flag_reg & ~(wr_flags & hwdata[FL_WRITE_COLLISION_FLAG]); // R18
        receive_overflow_flag_next = receive_overflow_flag_reg & ~(wr_flags & hwdata[FL_OVF]);
        serial_interrupt_flag_next = serial_interrupt_flag_reg & ~(wr_flags & hwdata[FL_SIF]);
        bus_collision_flag_next = bus_collision_flag_reg & ~(wr_flags & hwdata[FL_BCL]);
        start_seen_next = start_seen_reg & ~(wr_flags & hwdata[FL_START]);
        // Buffer writes while anything is underway are dropped
        if (wr_buf && (state_reg != S_IDLE || req_pending)) begin
            write_collision_flag_next = 1'h1; // R6 R18
        end
        unique case (state_reg)
            S_IDLE: begin
                if (wr_buf && !req_pending) begin
                    transfer_buffer_next = hwdata[BYTE_W-1:0];
                    shift_register_next = hwdata[BYTE_W-1:0];
                    buffer_full_flag_next = 1'h1; // R13
                    mode_next = MODE_TX;
                    bitcnt_next = '0;
                    scl_oe_next = 1'h1;
                    brg_load = 1'h1; // R13
                    state_next = B_LOW;
                end else if (start_request_reg) begin
                    if (sda_q_reg && scl_q_reg) begin
                        brg_load = 1'h1; // R3
                        state_next = S_CHK;
                    end else begin
                        start_request_next = 1'h0; // R5
                        bus_collision_flag_next = 1'h1; // R5
                    end
                end else if (repeated_start_request_reg) begin
                    scl_oe_next = 1'h1; // R8
                    state_next = R_LOW;
                end else if (receive_enable_bit_reg || ack_sequence_enable_reg) begin
                    mode_next = receive_enable_bit_reg ? MODE_RX : MODE_ACK; // R19
                    bitcnt_next = '0;
                    scl_oe_next = 1'h1;
                    brg_load = 1'h1;
                    state_next = B_LOW;
                end
            end
            S_CHK: begin
                if (!scl_q_reg || (brg_done && !sda_q_reg)) begin
                    start_request_next = 1'h0; // R5
                    bus_collision_flag_next = 1'h1; // R5
                    state_next = S_IDLE;
                end else if (brg_done) begin
                    sda_oe_next = 1'h1; // R3
                    start_seen_next = 1'h1; // R3 R10
                    brg_load = 1'h1; // R4
                    state_next = S_HOLD;
                end
            end
            S_HOLD: begin
                if (brg_done) begin
                    start_request_next = 1'h0; // R4
                    serial_interrupt_flag_next = 1'h1; // R10
                    state_next = S_IDLE;
                end
            end
            R_LOW: begin
                if (!scl_q_reg) begin
                    sda_oe_next = 1'h0; // R8
                    brg_load = 1'h1; // R8
                    state_next = R_REL;
                end
            end
            R_REL: begin
                if (brg_done) begin
                    if (sda_q_reg) begin
                        scl_oe_next = 1'h0; // R8
                        state_next = R_WAITH;
                    end else begin
                        repeated_start_request_next = 1'h0; // R12
                        bus_collision_flag_next = 1'h1; // R12
                        scl_oe_next = 1'h0;
                        state_next = S_IDLE;
                    end
                end
            end
            R_WAITH: begin
                if (scl_q_reg) begin
                    if (!sda_q_reg) begin
                        repeated_start_request_next = 1'h0; // R12
                        bus_collision_flag_next = 1'h1; // R12
                        state_next = S_IDLE;
                    end else begin
                        brg_load = 1'h1; // R1 R9
                        state_next = R_HIGH;
                    end
                end
            end
            R_HIGH: begin
                if (!scl_q_reg || !sda_q_reg) begin
                    repeated_start_request_next = 1'h0; // R12
                    bus_collision_flag_next = 1'h1; // R12
                    state_next = S_IDLE;
                end else if (brg_done) begin
                    sda_oe_next = 1'h1; // R9
                    start_seen_next = 1'h1; // R10
                    brg_load = 1'h1;
                    state_next = R_SDA;
                end
            end
            R_SDA: begin
                if (brg_done) begin
                    repeated_start_request_next = 1'h0; // R9
                    serial_interrupt_flag_next = 1'h1; // R10
                    state_next = S_IDLE;
                end
            end
            B_LOW: begin
                // Data changes only once SCL reads low
                if (!scl_q_reg) begin // R14
                    sda_oe_next = (mode_reg == MODE_ACK) ? ~ack_value_bit_reg
                        : (mode_reg == MODE_TX && bitcnt_reg != BIT_ACK
                        && !shift_register_reg[BYTE_W-1]); // R15
                end
                if (brg_done) begin
                    scl_oe_next = 1'h0; // R14
                    state_next = B_WAITH;
                end
            end
            B_WAITH: begin
                if (scl_q_reg) begin
                    brg_load = 1'h1; // R1 R2
                    state_next = B_HIGH;
                end
            end
            B_HIGH: begin
                if (brg_done) begin
                    scl_oe_next = 1'h1; // R14
                    bitcnt_next = bitcnt_reg + BIT_ONE;
                    brg_load = 1'h1;
                    state_next = B_LOW;
                    unique case (mode_reg)
                        MODE_TX: begin
                            shift_register_next = {shift_register_reg[BYTE_W-2:0], 1'h0};
                            if (bitcnt_reg == BIT_LAST_DATA) begin
                                buffer_full_flag_next = 1'h0; // R15
                            end
                            if (bitcnt_reg == BIT_ACK) begin
                                ack_status_bit_next = sda_q_reg; // R16
                                serial_interrupt_flag_next = 1'h1; // R17
                                brg_load = 1'h0; // R17
                                state_next = S_IDLE;
                            end
                        end
                        MODE_RX: begin
                            shift_register_next = {shift_register_reg[BYTE_W-2:0], sda_q_reg};
                            if (bitcnt_reg == BIT_LAST_DATA) begin
                                receive_enable_bit_next = 1'h0; // R20
                                transfer_buffer_next = shift_register_next; // R20
                                receive_overflow_flag_next = receive_overflow_flag_next
                                    | buffer_full_flag_reg; // R22
                                buffer_full_flag_next = 1'h1; // R20
                                serial_interrupt_flag_next = 1'h1; // R20
                                brg_load = 1'h0; // R20
                                state_next = S_IDLE;
                            end
                        end
                        default: begin
                            ack_sequence_enable_next = 1'h0; // R21
                            serial_interrupt_flag_next = 1'h1;
                            brg_load = 1'h0;
                            state_next = S_IDLE;
                        end
                    endcase
                end
            end
            default: state_next = S_IDLE;
        endcase
        // Baud counter: reload, count down on steps, stop at zero
        brg_next = brg_reg;
        brg_run_next = brg_run_reg;
        if (brg_load) begin
            brg_next = address_baud_reg; // R23
            brg_run_next = 1'h1;
        end else if (brg_done) begin
            brg_run_next = 1'h0; // R23
        end else if (tick_reg && brg_run_reg) begin
            brg_next = brg_reg - BRG_ONE; // R24
        end
    end
    // Sequencer state and flag registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= S_IDLE;
            mode_reg <= MODE_TX;
            address_baud_reg <= BAUD_RESET;
            {brg_reg, brg_run_reg, bitcnt_reg, shift_register_reg, transfer_buffer_reg} <= '0;
            {start_request_reg, repeated_start_request_reg, receive_enable_bit_reg} <= '0;
            {ack_sequence_enable_reg, ack_value_bit_reg, ack_status_bit_reg} <= '0;
            {buffer_full_flag_reg, write_collision_flag_reg, receive_overflow_flag_reg} <= '0;
            {serial_interrupt_flag_reg, bus_collision_flag_reg, start_seen_reg} <= '0;
            {scl_oe_reg, sda_oe_reg, pin_low_reg} <= '0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            address_baud_reg <= address_baud_next;
            {brg_reg, brg_run_reg, bitcnt_reg, shift_register_reg} <= {brg_next, brg_run_next,
                bitcnt_next, shift_register_next};
            {transfer_buffer_reg, start_request_reg, repeated_start_request_reg} <= {
                transfer_buffer_next, start_request_next, repeated_start_request_next};
            {receive_enable_bit_reg, ack_sequence_enable_reg, ack_value_bit_reg} <= {
                receive_enable_bit_next, ack_sequence_enable_next, ack_value_bit_next};
            {ack_status_bit_reg, buffer_full_flag_reg, write_collision_flag_reg} <= {
                ack_status_bit_next, buffer_full_flag_next, write_collision_flag_next};
            {receive_overflow_flag_reg, serial_interrupt_flag_reg, bus_collision_flag_reg} <= {
                receive_overflow_flag_next, serial_interrupt_flag_next, bus_collision_flag_next};
            {start_seen_reg, scl_oe_reg, sda_oe_reg} <= {start_seen_next, scl_oe_next, sda_oe_next};
            pin_low_reg <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops
    assign hreadyout = ~pin_low_reg;
    assign hresp = HRESP_OKAY ^ pin_low_reg;
    assign hrdata = hrdata_reg;
    assign scl_o = pin_low_reg;
    assign sda_o = pin_low_reg;
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;
endmodule
`default_nettype wire

/* test/ims_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ims_slave_model (
    input wire logic hclk, // Sampling clock
    input wire logic scl, // Clock line
    input wire logic sda, // Data line
    input wire logic rd, // Send data
    input wire logic stretch, // Hold clock after falls
    input wire logic [7:0] tx_byte, // Byte sent
    output logic scl_pull, // Clock pulled low
    output logic sda_pull // Data pulled low
);
    logic ps = 1'b1;
    logic pd = 1'b1;
    logic [3:0] cnt = 4'hf;
    logic [2:0] st = 3'h0;
    // Falls since start, stretch after each fall
    always @(posedge hclk) begin
        ps <= scl;
        pd <= sda;
        if (ps && scl && pd && !sda) cnt <= 4'hf;
        else if (ps && !scl) cnt <= (cnt == (rd ? 4'h7 : 4'h8)) ? 4'h0 : cnt + 4'h1;
        if (ps && !scl) st <= stretch ? 3'h6 : 3'h0;
        else if (st != 3'h0) st <= st - 3'h1;
    end
    assign scl_pull = st != 3'h0;
    // Data MSB first, else acknowledge in ninth bit
    assign sda_pull = rd ? (cnt < 4'h8 && !tx_byte[3'h7 - cnt[2:0]]) : cnt == 4'h8;
endmodule
`default_nettype wire

/* test/ims_master_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ims_master_checker (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset
    input wire logic scl_i, // Clock line
    input wire logic scl_oe, // Clock pull
    input wire logic sda_oe // Data pull
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Line timing
    property p_arb; !scl_oe && !scl_i |=> !scl_oe; endproperty
    a_arb: assert property (p_arb) else $error("clock pulled while held");
    property p_hi; $rose(scl_i) && !scl_oe |-> !scl_oe [*4]; endproperty
    a_hi: assert property (p_hi) else $error("high phase short");
    property p_fell; $fell(scl_oe) |-> !scl_oe [*4]; endproperty
    a_fell: assert property (p_fell) else $error("release short");
    property p_low; $rose(scl_oe) |-> scl_oe [*2]; endproperty
    a_low: assert property (p_low) else $error("low phase short");
    property p_sok; $rose(sda_oe) && !scl_oe |-> scl_i; endproperty
    a_sok: assert property (p_sok) else $error("start with clock low");
    property p_pre; $rose(sda_oe) && !scl_oe |-> !$past(scl_oe, 3) && !$past(sda_oe, 3);
    endproperty
    a_pre: assert property (p_pre) else $error("lines not high before start");
    property p_hold; $rose(sda_oe) && !scl_oe |=> !scl_oe [*2]; endproperty
    a_hold: assert property (p_hold) else $error("start hold short");
    property p_rel; $fell(sda_oe) |-> scl_oe; endproperty
    a_rel: assert property (p_rel) else $error("data released with clock high");
    c_start: cover property ($rose(sda_oe) && !scl_oe);
    c_str: cover property (!scl_oe && !scl_i);
    c_fell: cover property ($fell(scl_oe));
endmodule
bind ims_master ims_master_checker i_ims_master_checker(.hclk, .hresetn, .scl_i, .scl_oe,
    .sda_oe);
`default_nettype wire

/* test/ims_master_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
module ims_master_tb;
    import ims_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic tb_sda = 1'b0, rd = 1'b0, stretch = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, lf = 32'h459e_c1ee, hrdata, q;
    logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, s_scl, s_sda, scl, sda;
    logic [7:0] b = 8'h0;
    int n_fail = 0;
    int n_compared = 0;
    // Open-drain lines with pull-ups
    assign scl = ~(scl_oe | s_scl);
    assign sda = ~(sda_oe | s_sda | tb_sda);
    always #2.5 hclk = ~hclk;
    ims_master i_ims_master(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .scl_i(scl), .scl_o,
        .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
    ims_slave_model i_ims_slave_model(.hclk, .scl, .sda, .rd, .stretch, .tx_byte(b),
        .scl_pull(s_scl), .sda_pull(s_sda));
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [31:0] f(input int k);
        return 32'h1 << k;
    endfunction
    task automatic finish_test;
        if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1) begin n_fail++; finish_test; end
    endtask
    // One AHB single transfer
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
        rdy;
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        rdy;
        r = hrdata;
    endtask
    task automatic poll(input int k);
        q = 32'h0;
        for (int i = 0; i < 5000 && q[k] !== 1'b1; i++) xf(1'b0, OFS_FLAGS, 32'h0, q);
        if (q[k] !== 1'b1) begin n_fail++; finish_test; end
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        xf(1'b0, 8'h40, 32'h0, q); `CHK("unmapped", 32'h0, q)
        tb_sda <= 1'b1;
        repeat (4) @(posedge hclk);
        xf(1'b1, OFS_CTRL2, f(C2_SEN), q); poll(FL_BCL);
        tb_sda <= 1'b0;
        xf(1'b0, OFS_CTRL2, 32'h0, q); `CHK("sen", 1'b0, q[C2_SEN])
        lf = nx(lf);
        xf(1'b1, OFS_BAUD, lf, q); xf(1'b0, OFS_BAUD, 32'h0, q);
        `CHK("baud", {25'h0, lf[6:0]}, q)
        xf(1'b1, OFS_FLAGS, 32'h1f, q); xf(1'b1, OFS_CTRL2, f(C2_SEN), q);
        xf(1'b1, OFS_BUFFER, 32'h5a, q); xf(1'b1, OFS_CTRL2, f(C2_RECEIVE_ENABLE_BIT), q); poll(FL_SIF);
        xf(1'b0, OFS_FLAGS, 32'h0, q); `CHK("flags", f(FL_WRITE_COLLISION_FLAG) | f(FL_SIF) | f(FL_START), q)
        xf(1'b0, OFS_CTRL2, 32'h0, q); `CHK("ctrl2", 32'h0, q)
        lf = nx(lf); b = lf[15:8]; stretch <= lf[16];
        xf(1'b1, OFS_FLAGS, 32'h1f, q); xf(1'b1, OFS_BUFFER, {24'h0, lf[7:1], 1'b1}, q);
        xf(1'b1, OFS_BUFFER, 32'h0, q); xf(1'b0, OFS_STATUS, 32'h0, q);
        `CHK("status", 32'h3, q)
        poll(FL_SIF);
        xf(1'b0, OFS_CTRL2, 32'h0, q); `CHK("ack", 1'b0, q[C2_ACK_STATUS_BIT])
        xf(1'b0, OFS_FLAGS, 32'h0, q); `CHK("write_collision_flag", f(FL_WRITE_COLLISION_FLAG) | f(FL_SIF), q)
        xf(1'b0, OFS_STATUS, 32'h0, q); `CHK("idle", 32'h0, q)
        rd <= 1'b1;
        repeat (2) begin
            xf(1'b1, OFS_FLAGS, 32'h1f, q); xf(1'b1, OFS_CTRL2, f(C2_RECEIVE_ENABLE_BIT), q);
            xf(1'b1, OFS_CTRL2, f(C2_REPEATED_START_REQUEST), q); poll(FL_SIF);
        end
        xf(1'b0, OFS_FLAGS, 32'h0, q); `CHK("ovf", f(FL_OVF) | f(FL_SIF), q)
        xf(1'b0, OFS_BUFFER, 32'h0, q); `CHK("rx", {24'h0, b}, q)
        xf(1'b0, OFS_STATUS, 32'h0, q); `CHK("bf", 32'h0, q)
        rd <= 1'b0;
        xf(1'b1, OFS_FLAGS, 32'h1f, q); xf(1'b1, OFS_CTRL2, f(C2_REPEATED_START_REQUEST), q); poll(FL_SIF);
        xf(1'b0, OFS_FLAGS, 32'h0, q); `CHK("rstart", f(FL_SIF) | f(FL_START), q)
        xf(1'b0, OFS_CTRL2, 32'h0, q); `CHK("repeated_start_request", 32'h0, q)
        finish_test;
    end
endmodule
`default_nettype wire
